// [include/gspd_regs.svh]
// How it works
// - Three separate width tables are kept: 31 entries for A and C, 63 for B.
// - No entry exceeds 124 ticks and the pulse counter reaches that length.
// - Colors A and C use a 5-bit code and color B a 6-bit code.
// - Reset defaults rise 4 ticks per level for A and C and 2 for B.
// - The two lowest gray levels, codes 0 and 1, get pre-charge only and no current drive.
// - Opcode B8h loads table B, BCh loads table A and BDh loads table C.
// - Outputs switch on 100ms after the display-on command.
// - Reset returns every table and control value to its default.
// - Opcode B9h replaces all tables with the built-in linear table.
// - Each row runs four phases, drive last, then returns to reset phase, or to idle when outputs are off.
`ifndef GSPD_REGS_SVH
`define GSPD_REGS_SVH
`define GSPD_OP_LUT_B    8'hB8
`define GSPD_OP_LUT_A    8'hBC
`define GSPD_OP_LUT_C    8'hBD
`define GSPD_OP_LINEAR   8'hB9
`define GSPD_OP_DISP_ON  8'hAF
`define GSPD_OP_DISP_OFF 8'hAE
`define GSPD_LEVELS_AC   31
`define GSPD_LEVELS_B    63
`define GSPD_STEP_AC     4
`define GSPD_STEP_B      2
`define GSPD_MAX_WIDTH   124
`define GSPD_ON_DELAY_MS 100
`define GSPD_CLK_HZ      20000000
`define GSPD_PH1_TICKS   8'h04
`define GSPD_PH2_TICKS   8'h04
`define GSPD_PH3_TICKS   8'h04
`endif

// [include/gspd_pkg.sv]
`default_nettype none
package gspd_pkg;
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_RESET = 3'b001,
        PH_PRE1  = 3'b010,
        PH_PRE2  = 3'b011,
        PH_DRIVE = 3'b100
    } gspd_phase_t;
    typedef enum logic [1:0] {
        LD_NONE = 2'b00,
        LD_A    = 2'b01,
        LD_B    = 2'b10,
        LD_C    = 2'b11
    } gspd_load_t;
endpackage
`default_nettype wire

// [rtl/gspd_decoder.sv]
`include "gspd_regs.svh"
`default_nettype none
module gspd_decoder #(
    parameter int NSEG        = 4,
    parameter int ON_DELAY_CYC =
        `GSPD_ON_DELAY_MS * (`GSPD_CLK_HZ / 1000)
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CMD_VALID,
    input  wire logic              CMD_IS_DATA,
    input  wire logic [7:0]        CMD_BYTE,
    input  wire logic              DISPLAY_TICK,
    input  wire logic              ROW_START,
    input  wire logic [5*NSEG-1:0] CODE_A,
    input  wire logic [6*NSEG-1:0] CODE_B,
    input  wire logic [5*NSEG-1:0] CODE_C,
    output logic                   OUTPUTS_ON,
    output logic [2:0]             PHASE,
    output logic                   ROW_DONE,
    output logic [NSEG-1:0]        DRIVE_A,
    output logic [NSEG-1:0]        DRIVE_B,
    output logic [NSEG-1:0]        DRIVE_C
);
    logic [6:0] lut_a [1:`GSPD_LEVELS_AC];
    logic [6:0] lut_b [1:`GSPD_LEVELS_B];
    logic [6:0] lut_c [1:`GSPD_LEVELS_AC];
    gspd_pkg::gspd_load_t  load;
    logic [5:0]            load_idx;
    gspd_pkg::gspd_phase_t phase;
    logic [7:0]            ph_cnt;
    logic [6:0]            drv_cnt;
    logic [31:0]           on_cnt;
    logic                  on_pend;
    logic                  wr;
    logic [5:0]            last_idx;

    assign wr = CMD_VALID && CMD_IS_DATA && load != gspd_pkg::LD_NONE;
    assign last_idx = (load == gspd_pkg::LD_B) ? 6'(`GSPD_LEVELS_B)
                                               : 6'(`GSPD_LEVELS_AC);

    // Command routing and load progress
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            load     <= gspd_pkg::LD_NONE;
            load_idx <= 6'h01;
        end else if (CMD_VALID && !CMD_IS_DATA) begin
            load_idx <= 6'h01;
            case (CMD_BYTE)
                `GSPD_OP_LUT_B: load <= gspd_pkg::LD_B;
                `GSPD_OP_LUT_A: load <= gspd_pkg::LD_A;
                `GSPD_OP_LUT_C: load <= gspd_pkg::LD_C;
                default:        load <= gspd_pkg::LD_NONE;
            endcase
        end else if (wr) begin
            if (load_idx == last_idx) begin
                load <= gspd_pkg::LD_NONE;
            end
            load_idx <= load_idx + 6'h01;
        end
    end

    // Tables with linear defaults
    genvar g;
    generate
        for (g = 1; g <= `GSPD_LEVELS_B; g++) begin : g_lut_b
            always_ff @(posedge CLK) begin
                if (!RST_N || (CMD_VALID && !CMD_IS_DATA
                        && CMD_BYTE == `GSPD_OP_LINEAR)) begin
                    lut_b[g] <= 7'((g - 1) * `GSPD_STEP_B);
                end else if (wr && load == gspd_pkg::LD_B
                        && load_idx == 6'(g)) begin
                    lut_b[g] <= (CMD_BYTE > `GSPD_MAX_WIDTH)
                        ? 7'(`GSPD_MAX_WIDTH) : CMD_BYTE[6:0];
                end
            end
        end
        for (g = 1; g <= `GSPD_LEVELS_AC; g++) begin : g_lut_ac
            always_ff @(posedge CLK) begin
                if (!RST_N || (CMD_VALID && !CMD_IS_DATA
                        && CMD_BYTE == `GSPD_OP_LINEAR)) begin
                    lut_a[g] <= 7'((g - 1) * `GSPD_STEP_AC);
                    lut_c[g] <= 7'((g - 1) * `GSPD_STEP_AC);
                end else if (wr && load_idx == 6'(g)) begin
                    if (load == gspd_pkg::LD_A) begin
                        lut_a[g] <= (CMD_BYTE > `GSPD_MAX_WIDTH)
                            ? 7'(`GSPD_MAX_WIDTH) : CMD_BYTE[6:0];
                    end
                    if (load == gspd_pkg::LD_C) begin
                        lut_c[g] <= (CMD_BYTE > `GSPD_MAX_WIDTH)
                            ? 7'(`GSPD_MAX_WIDTH) : CMD_BYTE[6:0];
                    end
                end
            end
        end
    endgenerate

    // Display on delay
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            OUTPUTS_ON <= 1'b0;
            on_pend    <= 1'b0;
            on_cnt     <= 32'h0;
        end else if (CMD_VALID && !CMD_IS_DATA
                && CMD_BYTE == `GSPD_OP_DISP_OFF) begin
            OUTPUTS_ON <= 1'b0;
            on_pend    <= 1'b0;
        end else if (CMD_VALID && !CMD_IS_DATA
                && CMD_BYTE == `GSPD_OP_DISP_ON && !OUTPUTS_ON) begin
            on_pend <= 1'b1;
            on_cnt  <= 32'h0;
        end else if (on_pend) begin
            if (on_cnt == 32'(ON_DELAY_CYC - 1)) begin
                OUTPUTS_ON <= 1'b1;
                on_pend    <= 1'b0;
            end
            on_cnt <= on_cnt + 32'h1;
        end
    end

    // Four-phase row sequencer, counted in display ticks
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            phase    <= gspd_pkg::PH_IDLE;
            ph_cnt   <= 8'h00;
            drv_cnt  <= 7'h00;
            ROW_DONE <= 1'b0;
        end else begin
            ROW_DONE <= 1'b0;
            case (phase)
                gspd_pkg::PH_IDLE: begin
                    if (ROW_START && OUTPUTS_ON) begin
                        phase  <= gspd_pkg::PH_RESET;
                        ph_cnt <= 8'h00;
                    end
                end
                gspd_pkg::PH_RESET: begin
                    if (DISPLAY_TICK) begin
                        ph_cnt <= ph_cnt + 8'h01;
                        if (ph_cnt == `GSPD_PH1_TICKS - 8'h01) begin
                            phase  <= gspd_pkg::PH_PRE1;
                            ph_cnt <= 8'h00;
                        end
                    end
                end
                gspd_pkg::PH_PRE1: begin
                    if (DISPLAY_TICK) begin
                        ph_cnt <= ph_cnt + 8'h01;
                        if (ph_cnt == `GSPD_PH2_TICKS - 8'h01) begin
                            phase  <= gspd_pkg::PH_PRE2;
                            ph_cnt <= 8'h00;
                        end
                    end
                end
                gspd_pkg::PH_PRE2: begin
                    if (DISPLAY_TICK) begin
                        ph_cnt <= ph_cnt + 8'h01;
                        if (ph_cnt == `GSPD_PH3_TICKS - 8'h01) begin
                            phase   <= gspd_pkg::PH_DRIVE;
                            drv_cnt <= 7'h00;
                        end
                    end
                end
                gspd_pkg::PH_DRIVE: begin
                    if (DISPLAY_TICK) begin
                        drv_cnt <= drv_cnt + 7'h01;
                        if (drv_cnt == 7'(`GSPD_MAX_WIDTH - 1)) begin
                            ROW_DONE <= 1'b1;
                            phase    <= OUTPUTS_ON ? gspd_pkg::PH_RESET
                                                   : gspd_pkg::PH_IDLE;
                            ph_cnt   <= 8'h00;
                        end
                    end
                end
                default: phase <= gspd_pkg::PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PHASE <= 3'b000;
        end else begin
            PHASE <= phase;
        end
    end

    // Per-segment pulse comparison
    generate
        for (g = 0; g < NSEG; g++) begin : g_seg
            logic [4:0] ca;
            logic [5:0] cb;
            logic [4:0] cc;
            logic       drv;
            assign ca  = CODE_A[5*g +: 5];
            assign cb  = CODE_B[6*g +: 6];
            assign cc  = CODE_C[5*g +: 5];
            assign drv = phase == gspd_pkg::PH_DRIVE && OUTPUTS_ON;
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    DRIVE_A[g] <= 1'b0;
                    DRIVE_B[g] <= 1'b0;
                    DRIVE_C[g] <= 1'b0;
                end else begin
                    DRIVE_A[g] <= drv && ca > 5'h01
                        && drv_cnt < lut_a[ca];
                    DRIVE_B[g] <= drv && cb > 6'h01
                        && drv_cnt < lut_b[cb];
                    DRIVE_C[g] <= drv && cc > 5'h01
                        && drv_cnt < lut_c[cc];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [sim/gspd_decoder_assertions.sv]
`default_nettype none
module gspd_chk #(
    parameter int NSEG         = 4,
    parameter int ON_DELAY_CYC = 20
) (
    input wire logic              CLK,
    input wire logic              RST_N,
    input wire logic              CMD_VALID,
    input wire logic              CMD_IS_DATA,
    input wire logic [7:0]        CMD_BYTE,
    input wire logic              DISPLAY_TICK,
    input wire logic [5*NSEG-1:0] CODE_A,
    input wire logic              OUTPUTS_ON,
    input wire logic [2:0]        PHASE,
    input wire logic              ROW_DONE,
    input wire logic [NSEG-1:0]   DRIVE_A,
    input wire logic [NSEG-1:0]   DRIVE_B
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic        cmd;
    int unsigned since;
    logic [7:0]  run;
    assign cmd = CMD_VALID && !CMD_IS_DATA;
    always_ff @(posedge CLK) begin
        since <= (!RST_N || (cmd && CMD_BYTE == 8'hAF && !OUTPUTS_ON))
            ? 0 : since + 1;
    end
    always_ff @(posedge CLK) begin
        run <= (!RST_N || !DRIVE_B[1]) ? 8'h00
            : run + {7'h00, DISPLAY_TICK};
    end
    property p_on; $rose(OUTPUTS_ON) |-> since >= ON_DELAY_CYC - 1
        && since <= ON_DELAY_CYC + 1; endproperty
    a_on: assert property (p_on) else $error("on delay");
    property p_off; cmd && CMD_BYTE == 8'hAE |=> !OUTPUTS_ON; endproperty
    a_off: assert property (p_off) else $error("still on");
    property p_rst; $rose(RST_N) |-> !OUTPUTS_ON && PHASE == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("not cleared");
    property p_low; CODE_A[4:0] <= 5'h01 && $past(CODE_A[4:0]) <= 5'h01
        |-> !DRIVE_A[0]; endproperty
    a_low: assert property (p_low) else $error("low level drives");
    property p_max; run <= 8'h7C; endproperty
    a_max: assert property (p_max) else $error("pulse too long");
    property p_pulse; ROW_DONE |=> !ROW_DONE; endproperty
    a_pulse: assert property (p_pulse) else $error("done held");
    property p_next; ROW_DONE && OUTPUTS_ON |-> ##[0:3] PHASE == 3'h1;
    endproperty
    a_next: assert property (p_next) else $error("no next row");
    property p_drv; (|{DRIVE_A, DRIVE_B}) |-> PHASE == 3'h4
        || $past(PHASE) == 3'h4; endproperty
    a_drv: assert property (p_drv) else $error("drive off phase");
    c_on: cover property ($rose(OUTPUTS_ON));
    c_done: cover property (ROW_DONE);
    c_full: cover property (run == 8'h7C);
endmodule
bind gspd_decoder gspd_chk #(.NSEG(NSEG), .ON_DELAY_CYC(ON_DELAY_CYC))
    i_gspd_chk (.CLK(CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
    .DISPLAY_TICK(DISPLAY_TICK),
    .CMD_IS_DATA(CMD_IS_DATA), .CMD_BYTE(CMD_BYTE), .CODE_A(CODE_A),
    .OUTPUTS_ON(OUTPUTS_ON), .PHASE(PHASE), .ROW_DONE(ROW_DONE),
    .DRIVE_A(DRIVE_A), .DRIVE_B(DRIVE_B));
`default_nettype wire

// [sim/gspd_host.sv]
`default_nettype none
module gspd_host (
    input  wire logic  CLK,
    output var logic   CMD_VALID = 1'b0,
    output var logic   CMD_IS_DATA = 1'b0,
    output var logic [7:0] CMD_BYTE = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic send(input logic d, input logic [7:0] b);
        @(posedge CLK);
        CMD_VALID   <= 1'b1;
        CMD_IS_DATA <= d;
        CMD_BYTE    <= b;
        @(posedge CLK);
        CMD_VALID   <= 1'b0;
        CMD_BYTE    <= ~b; // Released bus shows no stale byte
    endtask
endmodule
`default_nettype wire

// [sim/gspd_decoder_tb.sv]
`default_nettype none
module gspd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = 4;
    localparam int DLY = 20;
    localparam int TDIV = 2;
    logic           CLK = 1'b0, RST_N = 1'b0, ROW_START = 1'b0;
    logic           tick = 1'b0;
    logic           cv, cd, on, rd;
    logic [7:0]     cb;
    logic [2:0]     ph;
    logic [5*N-1:0] ca = '0, cc = '0;
    logic [6*N-1:0] cbb = '0;
    logic [N-1:0]   da, db, dc;
    int n_errors = 0, compares = 0, cyc = 0, seed = 32'hF5880E24;
    int lut[3][64], cnt[3][N], code[3][N];
    initial forever #25 CLK = ~CLK;
    // Display tick on every second clock
    always @(posedge CLK) tick <= ~tick;
    gspd_host i_gspd_host (.CLK(CLK), .CMD_VALID(cv), .CMD_IS_DATA(cd),
        .CMD_BYTE(cb));
    gspd_decoder #(.NSEG(N), .ON_DELAY_CYC(DLY)) i_gspd_decoder (
        .CLK(CLK), .RST_N(RST_N), .CMD_VALID(cv), .CMD_IS_DATA(cd),
        .CMD_BYTE(cb), .DISPLAY_TICK(tick), .ROW_START(ROW_START),
        .CODE_A(ca), .CODE_B(cbb), .CODE_C(cc), .OUTPUTS_ON(on),
        .PHASE(ph), .ROW_DONE(rd), .DRIVE_A(da), .DRIVE_B(db), .DRIVE_C(dc));
    always @(posedge CLK) begin
        cyc++;
        for (int g = 0; g < N; g++) begin
            cnt[0][g] += (da[g] === 1'b1);
            cnt[1][g] += (db[g] === 1'b1);
            cnt[2][g] += (dc[g] === 1'b1);
        end
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task chk(input bit ok, input string m);
        compares++;
        if (!ok) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task dflt();
        for (int k = 1; k < 64; k++) begin
            lut[0][k] = 4 * (k - 1);
            lut[1][k] = 2 * (k - 1);
            lut[2][k] = 4 * (k - 1);
        end
    endtask
    task load(input int c, input logic [7:0] op, input int n, input int st);
        int v;
        i_gspd_host.send(1'b0, op);
        for (int k = 1; k <= n; k++) begin
            v = (k < 3) ? (k == 1 ? 1 : st)
                : st * (k - 1) - ($random(seed) & (st - 1));
            if (c == 2 && k == n) v = 200;
            lut[c][k] = (v > 124) ? 124 : v;
            i_gspd_host.send(1'b1, v[7:0]);
        end
    endtask
    task turn_on();
        i_gspd_host.send(1'b0, 8'hAF);
        repeat (DLY - 1) @(posedge CLK);
        #1 chk(on === 1'b0, "on early");
        @(posedge CLK);
        #1 chk(on === 1'b1, "not on");
        @(posedge CLK) ROW_START <= 1'b1;
        @(posedge CLK) ROW_START <= 1'b0;
    endtask
    task wait_ph(input logic [2:0] p);
        for (int i = 0; i < 400 && ph !== p; i++) @(posedge CLK) #1;
        chk(ph === p, "phase");
    endtask
    task row_chk(input string nm);
        int s[3][N];
        int m;
        @(posedge CLK);
        for (int g = 0; g < N; g++) begin
            for (int c = 0; c < 3; c++) begin
                m = (c == 1) ? 63 : 31;
                code[c][g] = g == 0 ? 1 : g == 1 ? m : $random(seed) & m;
            end
            ca[5*g+:5] <= code[0][g][4:0];
            cbb[6*g+:6] <= code[1][g][5:0];
            cc[5*g+:5] <= code[2][g][4:0];
        end
        wait_ph(3'h3);
        s = cnt;
        wait_ph(3'h4);
        wait_ph(3'h1);
        repeat (2) @(posedge CLK) #1;
        for (int g = 0; g < N; g++) for (int c = 0; c < 3; c++) begin
            m = code[c][g] <= 1 ? 0 : TDIV * lut[c][code[c][g]];
            chk(cnt[c][g] - s[c][g] == m, "width");
        end
        $display("test %s done", nm);
    endtask
    task give_verdict();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        dflt();
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        turn_on();
        row_chk("defaults");
        load(1, 8'hB8, 63, 2);
        load(0, 8'hBC, 31, 4);
        load(2, 8'hBD, 31, 4);
        i_gspd_host.send(1'b1, 8'h07);
        row_chk("tables");
        i_gspd_host.send(1'b0, 8'hB9);
        dflt();
        row_chk("linear");
        load(1, 8'hB8, 63, 2);
        @(posedge CLK) RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        dflt();
        turn_on();
        row_chk("reset");
        i_gspd_host.send(1'b0, 8'hAE);
        #1 chk(on === 1'b0, "still on");
        give_verdict();
    end
endmodule
`default_nettype wire
